// ---- hw/crypto_self_test_sequencer.sv ----
// Supervisor that runs power-on and conditional self-tests and gates services.
`timescale 1ns/1ps
// Behaviour
// - Any failure reports code, enters error state, except a random generator health failure while a power-on test is awaited or a key-pair failure in start-up
// - Only restart leaves error state
// - Power-on tests start by themselves
// - Power-on failure blocks all services
// - Firmware image digest checked at power-on
// - Cipher known-answer test at power-on
// - Cipher MAC known-answer test at power-on
// - Curve signature known-answer test at power-on
// - Keyed-hash test, also covers hash engine
// - Services only after all tests pass
// - Every reboot reruns the whole sequence
// - Key-pair generation consistency check
// - Entropy source tested continuously
// - Random generator health checks in operation
// - Verify signature before firmware upgrade
// - Approved mode entered after passing tests
// - Status answered only while healthy
// - Non-approved use leaves approved mode
module crypto_self_test_sequencer
  import self_test_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)(
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  // Power-on test engines
  output logic [5:0]      TEST_REQ_O,
  input  wire logic       TEST_DONE_I,
  input  wire logic       TEST_PASS_I,
  // Conditional test reports
  input  wire logic       KEYGEN_DONE_I,
  input  wire logic       KEYGEN_PASS_I,
  input  wire logic       ENTROPY_FAIL_I,
  input  wire logic       DRBG_HEALTH_FAIL_I,
  // Firmware upgrade
  input  wire logic       FW_LOAD_REQ_I,
  output logic            FW_SIG_REQ_O,
  input  wire logic       FW_SIG_DONE_I,
  input  wire logic       FW_SIG_PASS_I,
  output logic            FW_ACCEPT_O,
  output logic            FW_REJECT_O,
  // Service gate
  input  wire logic       SVC_REQ_I,
  input  wire logic       SVC_NONAPPROVED_I,
  output logic            SVC_GRANT_O,
  output logic            SVC_DENY_O,
  input  wire logic       STATUS_QUERY_I,
  output logic            STATUS_ACK_O,
  // Module state
  output logic            SELFTEST_BUSY_O,
  output logic            SERVICES_EN_O,
  output logic            APPROVED_MODE_O,
  output logic            ERROR_O,
  output logic [3:0]      ERROR_CODE_O
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    state_t     fsm;
    logic [2:0] idx;
    logic [5:0] req;
    logic       busy;
    logic       svc_en;
    logic       approved;
    logic       grant;
    logic       deny;
    logic       ack;
    logic       fw_req;
    logic       fw_accept;
    logic       fw_reject;
  } main_t;

  localparam main_t MAIN_RESET = '{
    fsm:       ST_REQ,
    idx:       TEST_INTEGRITY,
    req:       6'h00,
    busy:      1'b1,
    svc_en:    1'b0,
    approved:  1'b0,
    grant:     1'b0,
    deny:      1'b0,
    ack:       1'b0,
    fw_req:    1'b0,
    fw_accept: 1'b0,
    fw_reject: 1'b0
  };

  main_t      st;
  main_t      next_st;
  logic       fail;
  logic [3:0] fail_code;
  logic       timer_run;
  logic       timed_out;
  logic       err;
  logic [3:0] err_code;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  assign timer_run = (st.fsm == ST_WAIT) || (st.fsm == ST_FW);

  step_timer #(
    .LIMIT (TIMEOUT_CYCLES)
  ) u_timer (
    .clk_i     (CLK_I),
    .rst_n_i   (RST_N_I),
    .run_i     (timer_run),
    .expired_o (timed_out)
  );

  error_latch u_err (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .fail_i  (fail),
    .code_i  (fail_code),
    .err_o   (err),
    .code_o  (err_code)
  );

  // ****************************************************************
  // Failure detection
  // ****************************************************************
  // A hung engine is treated like a wrong answer, otherwise the token would
  // sit forever in start-up without ever reporting a fault.
  always_comb
  begin
    fail      = 1'b0;
    fail_code = ERR_NONE;
    if (st.fsm != ST_ERROR)
    begin
      if (ENTROPY_FAIL_I)
      begin
        fail      = 1'b1;
        fail_code = ERR_ENTROPY;
      end
      else if (DRBG_HEALTH_FAIL_I && st.fsm != ST_WAIT)
      begin
        fail      = 1'b1;
        fail_code = ERR_DRBG_HEALTH;
      end
      else if (KEYGEN_DONE_I && !KEYGEN_PASS_I && st.svc_en)
      begin
        fail      = 1'b1;
        fail_code = ERR_PAIRWISE;
      end
      else if (st.fsm == ST_WAIT && TEST_DONE_I && !TEST_PASS_I)
      begin
        fail      = 1'b1;
        fail_code = {1'b0, st.idx} + ERR_STEP;
      end
      else if (st.fsm == ST_FW && FW_SIG_DONE_I && !FW_SIG_PASS_I)
      begin
        fail      = 1'b1;
        fail_code = ERR_FW_SIG;
      end
      else if (timer_run && timed_out)
      begin
        fail      = 1'b1;
        fail_code = ERR_TIMEOUT;
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    next_st           = st;
    next_st.req       = 6'h00;
    next_st.grant     = 1'b0;
    next_st.deny      = 1'b0;
    next_st.ack       = 1'b0;
    next_st.fw_req    = 1'b0;
    next_st.fw_accept = 1'b0;
    next_st.fw_reject = 1'b0;
    if (fail)
    begin
      next_st.fsm       = ST_ERROR;
      next_st.busy      = 1'b0;
      next_st.svc_en    = 1'b0;
      next_st.approved  = 1'b0;
      next_st.fw_reject = (st.fsm == ST_FW);
    end
    else
    begin
      unique case (st.fsm)
        ST_REQ:
        begin
          // Tests run in a fixed order: image digest, cipher, cipher MAC,
          // curve signature, keyed hash (which exercises the hash engine)
          // and the random generator.
          next_st.req = TEST_REQ_ONE << st.idx;
          next_st.fsm = ST_WAIT;
        end
        ST_WAIT:
        begin
          if (TEST_DONE_I)
          begin
            if (st.idx == TEST_LAST)
            begin
              next_st.fsm      = ST_OPER;
              next_st.busy     = 1'b0;
              next_st.svc_en   = 1'b1;
              next_st.approved = 1'b1;
            end
            else
            begin
              next_st.idx = st.idx + 3'h1;
              next_st.fsm = ST_REQ;
            end
          end
        end
        ST_OPER:
        begin
          if (FW_LOAD_REQ_I)
          begin
            next_st.fsm    = ST_FW;
            next_st.fw_req = 1'b1;
          end
        end
        ST_FW:
        begin
          if (FW_SIG_DONE_I)
          begin
            next_st.fsm       = ST_OPER;
            next_st.fw_accept = 1'b1;
          end
        end
        ST_ERROR:
        begin
          next_st.svc_en = 1'b0;
        end
      endcase
    end

    // Services and status answers depend on the pass flag, the error latch and the live
    // failure, so a failure in flight always shuts the door first.
    if (SVC_REQ_I)
    begin
      if (st.svc_en && !err && !fail)
      begin
        next_st.grant = 1'b1;
        if (SVC_NONAPPROVED_I)
        begin
          next_st.approved = 1'b0;
        end
      end
      else
      begin
        next_st.deny = 1'b1;
      end
    end
    next_st.ack = STATUS_QUERY_I && st.svc_en && !err && !fail;
  end

  // Reset is the only restart path, and it always reloads the first test.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      st <= MAIN_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign TEST_REQ_O      = st.req;
  assign FW_SIG_REQ_O    = st.fw_req;
  assign FW_ACCEPT_O     = st.fw_accept;
  assign FW_REJECT_O     = st.fw_reject;
  assign SVC_GRANT_O     = st.grant;
  assign SVC_DENY_O      = st.deny;
  assign STATUS_ACK_O    = st.ack;
  assign SELFTEST_BUSY_O = st.busy;
  assign SERVICES_EN_O   = st.svc_en;
  assign APPROVED_MODE_O = st.approved;
  assign ERROR_O         = err;
  assign ERROR_CODE_O    = err_code;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  err_blocks_svc_a:
    assert property (ERROR_O |-> !SERVICES_EN_O && !SVC_GRANT_O)
    else $error("Services open while in error state.");

  err_sticky_a:
    assert property (ERROR_O |=> ERROR_O && $stable(ERROR_CODE_O))
    else $error("Error state left without restart.");

  auto_start_a:
    assert property ($rose(RST_N_I) |-> ##[1:2] TEST_REQ_O == TEST_REQ_ONE)
    else $error("Integrity test not started after reset.");

  busy_blocks_a:
    assert property (SELFTEST_BUSY_O |-> !SERVICES_EN_O && !STATUS_ACK_O)
    else $error("Services open during power-on tests.");

  integrity_code_a:
    assert property (TEST_REQ_O[0] ##[1:3] (TEST_DONE_I && !TEST_PASS_I && !ENTROPY_FAIL_I)
                     |=> ERROR_O && ERROR_CODE_O == ERR_INTEGRITY)
    else $error("Integrity failure not reported.");

  req_onehot_a:
    assert property ($onehot0(TEST_REQ_O))
    else $error("More than one engine asked at once.");

  pass_enables_a:
    assert property (TEST_REQ_O[5] ##[1:3] (TEST_DONE_I && TEST_PASS_I && !fail)
                     |=> SERVICES_EN_O && APPROVED_MODE_O)
    else $error("Services not enabled after last pass.");

  pairwise_a:
    assert property (SERVICES_EN_O && KEYGEN_DONE_I && !KEYGEN_PASS_I |=> ERROR_O)
    else $error("Key-pair failure not latched.");

  entropy_a:
    assert property (!ERROR_O && ENTROPY_FAIL_I
                     |=> ERROR_O && ERROR_CODE_O == ERR_ENTROPY)
    else $error("Entropy failure not latched.");

  fw_reject_a:
    assert property (FW_REJECT_O |-> ERROR_O && !FW_ACCEPT_O)
    else $error("Rejected image not flagged as error.");

  nonapproved_a:
    assert property (SVC_REQ_I && SVC_NONAPPROVED_I |=> !APPROVED_MODE_O)
    else $error("Non-approved use kept approved mode.");

  status_a:
    assert property (STATUS_ACK_O |-> SERVICES_EN_O && !ERROR_O)
    else $error("Status answered while unavailable.");

  all_pass_c:
    cover property ($rose(SERVICES_EN_O));
  error_c:
    cover property ($rose(ERROR_O));
  fw_accept_c:
    cover property (FW_SIG_REQ_O ##[1:20] FW_ACCEPT_O);
  status_c:
    cover property (STATUS_ACK_O);

endmodule : crypto_self_test_sequencer

// ---- hw/error_latch.sv ----
// Sticky error flag that keeps the first failure code until restart.
`timescale 1ns/1ps
module error_latch
  import self_test_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Failure report
  input  wire logic       fail_i,
  input  wire logic [3:0] code_i,
  // Latched state
  output logic            err_o,
  output logic [3:0]      code_o
);

  typedef struct packed {
    logic       err;
    logic [3:0] code;
  } latch_t;

  latch_t st;
  latch_t next_st;

  // Nothing but reset clears the flag, so the first cause is never overwritten.
  always_comb
  begin
    next_st = st;
    if (fail_i && !st.err)
    begin
      next_st.err  = 1'b1;
      next_st.code = code_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st <= '{err: 1'b0, code: ERR_NONE};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign err_o  = st.err;
  assign code_o = st.code;

endmodule : error_latch

// ---- hw/self_test_pkg.sv ----
// Shared constants and types for the cryptographic self-test supervisor.
package self_test_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned TEST_TIMEOUT_US = 100_000;
  localparam int unsigned TIMEOUT_CYC     = TEST_TIMEOUT_US * (CLK_HZ / 1_000_000);

  // ****************************************************************
  // Power-on test sequence, in the order it runs
  // ****************************************************************
  localparam int unsigned NUM_TESTS      = 6;
  localparam logic [2:0]  TEST_INTEGRITY = 3'h0;
  localparam logic [2:0]  TEST_CIPHER    = 3'h1;
  localparam logic [2:0]  TEST_CMAC      = 3'h2;
  localparam logic [2:0]  TEST_ECDSA     = 3'h3;
  localparam logic [2:0]  TEST_HMAC      = 3'h4;
  localparam logic [2:0]  TEST_DRBG      = 3'h5;
  localparam logic [2:0]  TEST_LAST      = TEST_DRBG;
  localparam logic [5:0]  TEST_REQ_ONE   = 6'h01;

  // ****************************************************************
  // Error codes, a power-on failure reports its test index plus one
  // ****************************************************************
  localparam logic [3:0] ERR_NONE        = 4'h0;
  localparam logic [3:0] ERR_INTEGRITY   = 4'h1;
  localparam logic [3:0] ERR_PAIRWISE    = 4'h7;
  localparam logic [3:0] ERR_ENTROPY     = 4'h8;
  localparam logic [3:0] ERR_DRBG_HEALTH = 4'h9;
  localparam logic [3:0] ERR_FW_SIG      = 4'ha;
  localparam logic [3:0] ERR_TIMEOUT     = 4'hb;
  localparam logic [3:0] ERR_STEP        = 4'h1;

  // ****************************************************************
  // Supervisor states
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_REQ   = 5'h01,
    ST_WAIT  = 5'h02,
    ST_OPER  = 5'h04,
    ST_FW    = 5'h08,
    ST_ERROR = 5'h10
  } state_t;

endpackage : self_test_pkg

// ---- hw/step_timer.sv ----
// Watchdog that flags an engine which never answers a test request.
`timescale 1ns/1ps
module step_timer
  import self_test_pkg::*;
#(
  parameter int unsigned LIMIT = TIMEOUT_CYC,
  parameter int unsigned CNT_W = $clog2(LIMIT + 1)
)(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic run_i,
  // Status
  output logic      expired_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             expired;
  } timer_t;

  timer_t st;
  timer_t next_st;

  always_comb
  begin
    next_st = st;
    if (!run_i)
    begin
      next_st = '0;
    end
    else if (!st.expired)
    begin
      if (st.cnt == CNT_W'(LIMIT - 1))
      begin
        next_st.expired = 1'b1;
      end
      else
      begin
        next_st.cnt = st.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign expired_o = st.expired;

endmodule : step_timer

// ---- verif/engine_model.sv ----
// Behavioural power-on test engines and new-image signature checker.
`timescale 1ns/1ps
module engine_model
(
  // Clock
  input  wire logic       clk_i,
  // Requests from the supervisor
  input  wire logic [5:0] req_i,
  input  wire logic       sig_req_i,
  // Scenario controls
  input  wire logic [2:0] fail_idx_i,
  input  wire logic [3:0] lag_i,
  input  wire logic       mute_i,
  input  wire logic       sig_ok_i,
  // Answers
  output logic            done_o,
  output logic            pass_o,
  output logic            sig_done_o,
  output logic            sig_pass_o
);
  int idx;

  initial
  begin
    done_o = 1'b0;
    pass_o = 1'b0;
    sig_done_o = 1'b0;
    sig_pass_o = 1'b0;
  end

  // ****************************************************************
  // Answers
  // ****************************************************************
  // Result lines are inverted once a strobe ends, so a stale value never reads as valid.
  always @(negedge clk_i)
  begin
    if (req_i != 6'h00 && !mute_i)
    begin
      for (int k = 0; k < 6; k++)
        if (req_i[k]) idx = k;
      repeat (lag_i) @(negedge clk_i);
      @(negedge clk_i);
      done_o = 1'b1;
      pass_o = (idx != int'(fail_idx_i));
      @(negedge clk_i);
      done_o = 1'b0;
      pass_o = ~pass_o;
    end
    else if (sig_req_i)
    begin
      repeat (lag_i) @(negedge clk_i);
      @(negedge clk_i);
      sig_done_o = 1'b1;
      sig_pass_o = sig_ok_i;
      @(negedge clk_i);
      sig_done_o = 1'b0;
      sig_pass_o = ~sig_pass_o;
    end
  end
endmodule : engine_model

// ---- verif/testbench.sv ----
// Self-checking bench for the self-test supervisor.
`timescale 1ns/1ps
module testbench
  import self_test_pkg::*;
;
  localparam logic [3:0] COND_CODE [3] = '{ERR_ENTROPY, ERR_DRBG_HEALTH, ERR_PAIRWISE};
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [5:0] ev = 6'h00;
  logic       kg_pass = 1'b1;
  logic       nonappr = 1'b0;
  logic [2:0] fail_idx = 3'h7;
  logic [3:0] lag = 4'h1;
  logic       mute = 1'b0;
  logic       sig_ok = 1'b1;
  logic [5:0] req;
  logic       done;
  logic       pass;
  logic       sig_req;
  logic       sig_done;
  logic       sig_pass;
  logic       accept;
  logic       reject;
  logic       grant;
  logic       deny;
  logic       ack;
  logic       busy;
  logic       en;
  logic       appr;
  logic       err;
  logic [3:0] code;
  int         n_fail = 0;
  int         tests_run = 0;
  int         i;

  always #25 clk = ~clk;

  crypto_self_test_sequencer #(.TIMEOUT_CYCLES(50)) dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .TEST_REQ_O(req), .TEST_DONE_I(done),
    .TEST_PASS_I(pass), .KEYGEN_DONE_I(ev[2]), .KEYGEN_PASS_I(kg_pass),
    .ENTROPY_FAIL_I(ev[0]), .DRBG_HEALTH_FAIL_I(ev[1]), .FW_LOAD_REQ_I(ev[3]),
    .FW_SIG_REQ_O(sig_req), .FW_SIG_DONE_I(sig_done), .FW_SIG_PASS_I(sig_pass),
    .FW_ACCEPT_O(accept), .FW_REJECT_O(reject), .SVC_REQ_I(ev[4]),
    .SVC_NONAPPROVED_I(nonappr), .SVC_GRANT_O(grant), .SVC_DENY_O(deny),
    .STATUS_QUERY_I(ev[5]), .STATUS_ACK_O(ack), .SELFTEST_BUSY_O(busy),
    .SERVICES_EN_O(en), .APPROVED_MODE_O(appr), .ERROR_O(err), .ERROR_CODE_O(code));

  engine_model partner_u (
    .clk_i(clk), .req_i(req), .sig_req_i(sig_req), .fail_idx_i(fail_idx), .lag_i(lag),
    .mute_i(mute), .sig_ok_i(sig_ok), .done_o(done), .pass_o(pass),
    .sig_done_o(sig_done), .sig_pass_o(sig_pass));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // The answer to a request is registered, so it is read at the falling edge after it is taken.
  task pulse(input int b);
    @(negedge clk);
    ev[b] = 1'b1;
    @(negedge clk);
    ev[b] = 1'b0;
  endtask : pulse

  task restart(input logic [2:0] fi, input logic mu);
    fail_idx = fi;
    mute = mu;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    chk({busy, en, appr, err}, 8'h08);
    chk({2'h0, req}, 8'h00);
    chk({4'h0, code}, 8'h00);
    rst_n = 1'b1;
  endtask : restart

  task boot_ok;
    restart(3'h7, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      for (i = 0; i < 50 && req == 6'h00; i++) @(negedge clk);
      chk(req, 6'h01 << k);
      chk(en, 8'h00);
      @(negedge clk);
    end
    for (i = 0; i < 50 && busy !== 1'b0; i++) @(negedge clk);
    chk({en, appr, busy, err}, 8'h0c);
  endtask : boot_ok

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_fail;
    for (int k = 0; k < 6; k++)
    begin
      restart(k[2:0], 1'b0);
      pulse(4);
      chk({grant, deny}, 8'h01);
      pulse(3);
      chk(sig_req, 8'h00);
      for (i = 0; i < 100 && err !== 1'b1; i++) @(negedge clk);
      chk(code, k[7:0] + 8'h01);
      chk({en, appr}, 8'h00);
      pulse(4);
      chk({grant, deny}, 8'h01);
      pulse(5);
      chk(ack, 8'h00);
      repeat (60) @(negedge clk);
      chk({err, code}, {4'h1, k[3:0] + 4'h1});
    end
    boot_ok;
  endtask : t_fail

  task t_svc;
    boot_ok;
    pulse(4);
    chk({grant, deny, appr}, 8'h05);
    pulse(5);
    chk(ack, 8'h01);
    nonappr = 1'b1;
    pulse(4);
    nonappr = 1'b0;
    chk({grant, appr, en}, 8'h05);
  endtask : t_svc

  // Engines here answer with no extra lag, the fastest turn-around allowed.
  task t_fw;
    lag = 4'h0;
    boot_ok;
    for (int k = 0; k < 2; k++)
    begin
      sig_ok = (k == 0);
      pulse(3);
      chk(sig_req, 8'h01);
      for (i = 0; i < 20 && !(accept | reject); i++) @(negedge clk);
      chk({accept, reject, err}, (k == 0) ? 8'h04 : 8'h03);
      @(negedge clk);
    end
    chk(code, ERR_FW_SIG);
    sig_ok = 1'b1;
    lag = 4'h1;
  endtask : t_fw

  task t_cond;
    boot_ok;
    pulse(2);
    chk(err, 8'h00);
    kg_pass = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      boot_ok;
      pulse(k);
      chk({err, en, appr}, 8'h04);
      chk(code, COND_CODE[k]);
    end
    kg_pass = 1'b1;
  endtask : t_cond

  // A silent engine must not leave the sequence waiting for ever.
  task t_timeout;
    restart(3'h7, 1'b1);
    for (i = 0; i < 200 && err !== 1'b1; i++) @(negedge clk);
    chk({en, code}, {4'h0, ERR_TIMEOUT});
    mute = 1'b0;
  endtask : t_timeout

  initial
  begin
    t_fail;
    t_svc;
    t_fw;
    t_cond;
    t_timeout;
    end_of_test;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test;
  end
endmodule : testbench
